// ### hw/alcs_blk.sv
// Purpose: picks one three digit decimal block of a value
// Assumes: blk 0 is the least significant block
// Notes: purely combinational
`timescale 1ns/100ps
`include "alcs_consts.svh"
module alcs_blk (
  input wire logic [31:0] value,
  input wire logic [1:0] blk,
  output logic [9:0] digits
);
  import alcs_pkg::*;
  logic [31:0] div;
  logic [31:0] quo;
  logic [31:0] rem;
  always_comb begin
    case (blk)
      2'h0: div = `ALCS_DIV_B0;
      2'h1: div = `ALCS_DIV_B1;
      2'h2: div = `ALCS_DIV_B2;
      default: div = `ALCS_DIV_B3;
    endcase
    quo = value / div;
    rem = quo % `ALCS_DIV_B1;
    digits = rem[9:0];
  end
endmodule

// ### hw/alcs_consts.svh
// Purpose: constants of the access lock and counter supervisor
// Assumes: 50 MHz mclk, synchronous active high reset
// Notes: times are kept in their own unit, cycle counts derived in code
//
// Overview of operation
// - IO-Link index 000C holds the access lock; bit 2 blocks keypad edits
// - remote lock outranks the PIN and survives leaving IO-Link mode
// - only an IO-Link write clears the remote lock, never the keypad
// - wrong PIN shows the failure message and menus stay locked
// - correct PIN opens edits; one minute without a change relocks
// - stored PIN 000 disables the menu lock permanently
// - the PIN resets to 000 so menus start unprotected
// - only PIN 001 to 999 enable the lock, keypad or IO-Link
// - factory reset restores configuration, setup and active profile
// - factory reset keeps counters, zero point and application tag
// - uncleared suction counter steps once per valid suction pulse
// - uncleared running counter steps once per second of run time
// - counter view starts at lowest block, right point flashing, keys step
// - serial number is shown in the same three digit blocks
// - holding up or down about three seconds scrolls fast
// - leaving an edit with a short menu press discards it; holding menu two seconds stores it
// - any error aborts the menu, shows its code, IO-Link reads it
// - board overtemperature switches the device off
// - supply out of tolerance enters an error state, shown and reported
// - four supply faults each have their own code
// - during a supply fault menus and inputs are ignored
// - during a supply fault the parts check output keeps working
// - during a supply fault vacuum generation is off
// - during a supply fault the up key shows supply voltages
`ifndef ALCS_CONSTS_SVH
`define ALCS_CONSTS_SVH

`define ALCS_CLK_NS 32'h00000014
`define ALCS_TICK_NS 32'h05F5E100
`define ALCS_SEC_NS 32'h3B9ACA00
`define ALCS_UNLOCK_S 32'h0000003C
`define ALCS_FAST_S 32'h00000003
`define ALCS_SAVE_S 32'h00000002

`define ALCS_IDX_LOCK 16'h000C
`define ALCS_LOCK_BIT 2
`define ALCS_IDX_PIN 16'h0040
`define ALCS_IDX_FRESET 16'h0041
`define ALCS_IDX_ERR 16'h0042
`define ALCS_IDX_CNT1_LO 16'h0043
`define ALCS_IDX_CNT1_HI 16'h0044
`define ALCS_IDX_CNT2_LO 16'h0045
`define ALCS_IDX_CNT2_HI 16'h0046
`define ALCS_IDX_TAG 16'h0047
`define ALCS_IDX_CFG 16'h0048
`define ALCS_IDX_PROF 16'h0049

`define ALCS_VAL_MAX 10'h3E7
`define ALCS_DIGIT_MAX 4'h9
`define ALCS_DIGIT_BASE 10'h00A
`define ALCS_PIN_LAST 2'h2
`define ALCS_BLK_LAST 2'h3
`define ALCS_PIN_RST 10'h000
`define ALCS_CFG_RST 10'h000
`define ALCS_PROF_RST 10'h000
`define ALCS_LOCK_RST 16'h0000
`define ALCS_TAG_RST 16'h0000

`define ALCS_ERR_NONE 8'h00
`define ALCS_ERR_UA_LOW 8'h05
`define ALCS_ERR_US_LOW 8'h07
`define ALCS_ERR_UA_HIGH 8'h15
`define ALCS_ERR_US_HIGH 8'h17
`define ALCS_ERR_TEMP 8'h0C

`define ALCS_DIV_B0 32'h00000001
`define ALCS_DIV_B1 32'h000003E8
`define ALCS_DIV_B2 32'h000F4240
`define ALCS_DIV_B3 32'h3B9ACA00

`endif

// ### hw/alcs_pkg.sv
// Purpose: shared types of the access lock and counter supervisor
// Assumes: included constants header for numbers
// Notes: types only
package alcs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PIN, ST_EDIT, ST_VIEW, ST_FAULT
  } alcs_state_t;
  typedef enum logic [2:0] {
    MSG_NONE, MSG_PIN_OK, MSG_PIN_BAD, MSG_LOCKED, MSG_ERR
  } alcs_msg_t;
  typedef enum logic [2:0] {
    IT_CFG, IT_PROF, IT_PIN, IT_FRESET, IT_CNT1, IT_CNT2, IT_SERIAL
  } alcs_item_t;
endpackage

// ### hw/alcs_top.sv
// Purpose: access lock, PIN window, counters and fault supervision
// Assumes: keys, suction and fault pins are asynchronous
// Notes: IO-Link parameter port answers one cycle after a request
`timescale 1ns/100ps
`include "alcs_consts.svh"
module alcs_top #(
  parameter int unsigned TICK_CYC = `ALCS_TICK_NS / `ALCS_CLK_NS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic key_menu,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic suction_in,
  input wire logic sup_ua_low,
  input wire logic sup_ua_high,
  input wire logic sup_us_low,
  input wire logic sup_us_high,
  input wire logic temp_over,
  input wire logic parts_in,
  input wire logic [7:0] ext_err,
  input wire logic [9:0] volt_ua,
  input wire logic [9:0] volt_us,
  input wire logic [31:0] serial_no,
  input wire alcs_pkg::alcs_item_t sel_item,
  input wire logic iol_mode,
  input wire logic iol_wr,
  input wire logic iol_rd,
  input wire logic [15:0] iol_index,
  input wire logic [15:0] iol_wdata,
  output logic [15:0] iol_rdata,
  output logic iol_ack,
  output logic iol_nak,
  output logic [9:0] disp_val,
  output logic [3:0] disp_dp,
  output logic disp_blink,
  output alcs_pkg::alcs_msg_t disp_msg,
  output logic [7:0] err_code,
  output logic vac_en,
  output logic parts_out,
  output logic pump_off,
  output logic write_grant
);
  import alcs_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
  localparam logic [3:0] TICKS_SEC = 4'(`ALCS_SEC_NS / `ALCS_TICK_NS);
  localparam logic [9:0] UNLOCK_TICKS = 10'(`ALCS_UNLOCK_S * TICKS_SEC);
  localparam logic [7:0] FAST_TICKS = 8'(`ALCS_FAST_S * TICKS_SEC);
  localparam logic [7:0] SAVE_TICKS = 8'(`ALCS_SAVE_S * TICKS_SEC);

  // two stage synchronisers plus edge stage for the key, suction, supply and temperature pins
  logic [8:0] pin_raw, s1_r, s2_r, s3_r;
  assign pin_raw = {key_menu, key_up, key_down, suction_in, sup_ua_low,
                    sup_ua_high, sup_us_low, sup_us_high, temp_over};
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_r <= 9'h000;
      s2_r <= 9'h000;
      s3_r <= 9'h000;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic menu_s, up_s, down_s, suc_s, menu_fall, up_rise, down_rise, suc_rise;
  logic ua_low, ua_high, us_low, us_high, temp_s, fault;
  assign menu_s = s2_r[8];
  assign up_s = s2_r[7];
  assign down_s = s2_r[6];
  assign suc_s = s2_r[5];
  assign ua_low = s2_r[4];
  assign ua_high = s2_r[3];
  assign us_low = s2_r[2];
  assign us_high = s2_r[1];
  assign temp_s = s2_r[0];
  assign menu_fall = !menu_s && s3_r[8];
  assign up_rise = up_s && !s3_r[7];
  assign down_rise = down_s && !s3_r[6];
  assign suc_rise = suc_s && !s3_r[5];
  assign fault = ua_low || ua_high || us_low || us_high;

  // tick and second dividers
  logic [31:0] tick_cnt_r;
  logic [3:0] sec_cnt_r;
  logic tick_c, sec_tick_r;
  assign tick_c = (tick_cnt_r == TICK_LAST);
  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt_r <= 32'h0;
      sec_cnt_r <= 4'h0;
      sec_tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_c ? 32'h0 : tick_cnt_r + 32'h1;
      sec_tick_r <= 1'b0;
      if (tick_c) begin
        if (sec_cnt_r == TICKS_SEC - 4'h1) begin
          sec_cnt_r <= 4'h0;
          sec_tick_r <= 1'b1;
        end else begin
          sec_cnt_r <= sec_cnt_r + 4'h1;
        end
      end
    end
  end

  // key hold timers
  logic [7:0] menu_hold_r, up_hold_r, down_hold_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      menu_hold_r <= 8'h00;
      up_hold_r <= 8'h00;
      down_hold_r <= 8'h00;
    end else begin
      if (!menu_s) menu_hold_r <= 8'h00;
      else if (tick_c && menu_hold_r != 8'hFF) menu_hold_r <= menu_hold_r + 8'h1;
      if (!up_s) up_hold_r <= 8'h00;
      else if (tick_c && up_hold_r != 8'hFF) up_hold_r <= up_hold_r + 8'h1;
      if (!down_s) down_hold_r <= 8'h00;
      else if (tick_c && down_hold_r != 8'hFF) down_hold_r <= down_hold_r + 8'h1;
    end
  end
  logic menu_short, menu_long, step_up, step_down;
  assign menu_short = menu_fall && (menu_hold_r < SAVE_TICKS);
  assign menu_long = menu_s && tick_c && (menu_hold_r == SAVE_TICKS - 8'h1);
  assign step_up = up_rise || (up_s && tick_c && up_hold_r >= FAST_TICKS);
  assign step_down = down_rise ||
                     (down_s && tick_c && down_hold_r >= FAST_TICKS);

  // error code, supply faults first
  logic [7:0] err_c;
  logic err_act;
  always_comb begin
    if (ua_low) err_c = `ALCS_ERR_UA_LOW;
    else if (ua_high) err_c = `ALCS_ERR_UA_HIGH;
    else if (us_low) err_c = `ALCS_ERR_US_LOW;
    else if (us_high) err_c = `ALCS_ERR_US_HIGH;
    else if (temp_s) err_c = `ALCS_ERR_TEMP;
    else err_c = ext_err;
  end
  assign err_act = (err_c != `ALCS_ERR_NONE);

  // stored parameters and lock state
  logic [9:0] cfg_r, prof_r, pin_r, edit_r, pin_acc_r;
  logic [15:0] lock_r, tag_r;
  logic win_act_r;
  logic [9:0] win_cnt_r;
  logic lock_bit, grant_c, iol_w_c, iol_r_c, freset_c, commit_c;
  logic pin_ok_c, wr_rng;
  alcs_state_t state_r;
  alcs_item_t item_r;
  logic [3:0] dig_r;
  logic [1:0] pin_pos_r, blk_r;
  logic [9:0] pin_try_c;
  assign lock_bit = lock_r[`ALCS_LOCK_BIT];
  assign grant_c = !lock_bit &&
                   (pin_r == `ALCS_PIN_RST || win_act_r);
  assign iol_w_c = iol_mode && iol_wr;
  assign iol_r_c = iol_mode && iol_rd;
  assign wr_rng = (iol_wdata <= {6'h00, `ALCS_VAL_MAX});
  assign commit_c = (state_r == ST_EDIT) && menu_long && grant_c;
  assign freset_c = (iol_w_c && iol_index == `ALCS_IDX_FRESET) ||
                    (commit_c && item_r == IT_FRESET);
  assign pin_try_c = 10'(pin_acc_r * `ALCS_DIGIT_BASE + {6'h00, dig_r});
  assign pin_ok_c = (state_r == ST_PIN) && menu_short && !lock_bit &&
                    pin_pos_r == `ALCS_PIN_LAST &&
                    pin_try_c == pin_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_r <= `ALCS_PIN_RST;
      cfg_r <= `ALCS_CFG_RST;
      prof_r <= `ALCS_PROF_RST;
    end else if (freset_c) begin
      pin_r <= `ALCS_PIN_RST;
      cfg_r <= `ALCS_CFG_RST;
      prof_r <= `ALCS_PROF_RST;
    end else if (iol_w_c && wr_rng) begin
      if (iol_index == `ALCS_IDX_PIN) pin_r <= iol_wdata[9:0];
      if (iol_index == `ALCS_IDX_CFG) cfg_r <= iol_wdata[9:0];
      if (iol_index == `ALCS_IDX_PROF) prof_r <= iol_wdata[9:0];
    end else if (commit_c) begin
      if (item_r == IT_PIN) pin_r <= edit_r;
      if (item_r == IT_CFG) cfg_r <= edit_r;
      if (item_r == IT_PROF) prof_r <= edit_r;
    end
  end
  // lock and tag change only over IO-Link, never by factory reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      lock_r <= `ALCS_LOCK_RST;
      tag_r <= `ALCS_TAG_RST;
    end else if (iol_w_c) begin
      if (iol_index == `ALCS_IDX_LOCK) lock_r <= iol_wdata;
      if (iol_index == `ALCS_IDX_TAG) tag_r <= iol_wdata;
    end
  end
  a_lock_iol_only: assert property ($fell(lock_bit) |->
    $past(iol_w_c && iol_index == `ALCS_IDX_LOCK))
    else $error("remote lock cleared without an IO-Link write");
  a_tag_kept: assert property (freset_c &&
    !(iol_w_c && iol_index == `ALCS_IDX_TAG) |=> $stable(tag_r))
    else $error("factory reset changed the tag");
  a_pin_range: assert property (iol_w_c && iol_index == `ALCS_IDX_PIN &&
    !wr_rng && !commit_c |=> $stable(pin_r))
    else $error("out of range PIN accepted");

  // one minute unlock window
  always_ff @(posedge mclk) begin
    if (reset) begin
      win_act_r <= 1'b0;
      win_cnt_r <= 10'h000;
    end else if (pin_ok_c || commit_c) begin
      win_act_r <= 1'b1;
      win_cnt_r <= UNLOCK_TICKS;
    end else if (win_act_r && tick_c) begin
      if (win_cnt_r == 10'h001) win_act_r <= 1'b0;
      win_cnt_r <= win_cnt_r - 10'h001;
    end
  end
  sequence s_win_last;
    win_act_r && win_cnt_r == 10'h001 && tick_c && !pin_ok_c && !commit_c;
  endsequence
  a_win_expire: assert property (s_win_last |=> !win_act_r)
    else $error("unlock window did not close");
  a_lock_wins: assert property (lock_bit |=> !write_grant)
    else $error("write granted under remote lock");
  a_pin_zero: assert property (pin_r == `ALCS_PIN_RST && !lock_bit
    |=> write_grant)
    else $error("PIN 000 did not open the menus");

  // menu state machine
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      item_r <= IT_CFG;
      dig_r <= 4'h0;
      pin_pos_r <= 2'h0;
      pin_acc_r <= 10'h000;
      edit_r <= 10'h000;
      blk_r <= 2'h0;
      disp_msg <= MSG_NONE;
    end else if (fault) begin
      state_r <= ST_FAULT;
      disp_msg <= MSG_ERR;
    end else if (err_act) begin
      state_r <= ST_IDLE;
      disp_msg <= MSG_ERR;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (menu_short) begin
            item_r <= sel_item;
            blk_r <= 2'h0;
            disp_msg <= MSG_NONE;
            if (sel_item == IT_CNT1 || sel_item == IT_CNT2 ||
                sel_item == IT_SERIAL) begin
              state_r <= ST_VIEW;
            end else if (lock_bit) begin
              disp_msg <= MSG_LOCKED;
            end else if (!grant_c) begin
              state_r <= ST_PIN;
              dig_r <= 4'h0;
              pin_pos_r <= 2'h0;
              pin_acc_r <= 10'h000;
            end else begin
              state_r <= ST_EDIT;
              edit_r <= (sel_item == IT_PIN) ? pin_r :
                        (sel_item == IT_PROF) ? prof_r : cfg_r;
            end
          end
        end
        ST_PIN: begin
          if (step_up) dig_r <= (dig_r == `ALCS_DIGIT_MAX) ? 4'h0 : dig_r + 4'h1;
          else if (step_down)
            dig_r <= (dig_r == 4'h0) ? `ALCS_DIGIT_MAX : dig_r - 4'h1;
          else if (menu_short) begin
            dig_r <= 4'h0;
            pin_acc_r <= pin_try_c;
            pin_pos_r <= pin_pos_r + 2'h1;
            if (pin_pos_r == `ALCS_PIN_LAST) begin
              state_r <= ST_IDLE;
              disp_msg <= pin_ok_c ? MSG_PIN_OK : MSG_PIN_BAD;
            end
          end
        end
        ST_EDIT: begin
          if (step_up && edit_r != `ALCS_VAL_MAX) edit_r <= edit_r + 10'h001;
          else if (step_down && edit_r != 10'h000) edit_r <= edit_r - 10'h001;
          else if (menu_short || menu_long) state_r <= ST_IDLE;
        end
        ST_VIEW: begin
          if (step_up && blk_r != `ALCS_BLK_LAST) blk_r <= blk_r + 2'h1;
          else if (step_down && blk_r != 2'h0) blk_r <= blk_r - 2'h1;
          else if (menu_short) state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
          disp_msg <= MSG_NONE;
        end
      endcase
    end
  end
  sequence s_pin_miss;
    state_r == ST_PIN && menu_short && pin_pos_r == `ALCS_PIN_LAST &&
    !pin_ok_c && !err_act && !fault && !step_up && !step_down;
  endsequence
  a_pin_fail: assert property (s_pin_miss |=>
    disp_msg == MSG_PIN_BAD && !win_act_r && state_r == ST_IDLE)
    else $error("wrong PIN did not keep menus locked");
  a_err_abort: assert property (err_act && !fault |=>
    state_r == ST_IDLE && disp_msg == MSG_ERR)
    else $error("error did not abort the menu");
  a_edit_discard: assert property (state_r == ST_EDIT && menu_short &&
    !iol_w_c && !err_act && !fault && !step_up && !step_down
    |=> $stable(cfg_r) && state_r == ST_IDLE)
    else $error("discarded edit was stored");

  // counters that no command clears
  logic [31:0] cnt1_r, cnt2_r;
  always_ff @(posedge mclk) begin
    if (reset) cnt1_r <= 32'h0;
    else if (suc_rise && !fault) cnt1_r <= cnt1_r + 32'h1;
  end
  always_ff @(posedge mclk) begin
    if (reset) cnt2_r <= 32'h0;
    else if (sec_tick_r) cnt2_r <= cnt2_r + 32'h1;
  end
  a_cnt1_step: assert property (suc_rise && !fault |=>
    cnt1_r == $past(cnt1_r) + 32'h1)
    else $error("suction counter missed a pulse");
  a_cnt2_step: assert property (sec_tick_r |=>
    cnt2_r == $past(cnt2_r) + 32'h1)
    else $error("running counter missed a second");

  // display path
  logic [31:0] view_src;
  logic [9:0] blk_digits;
  logic volt_sel_r;
  assign view_src = (item_r == IT_CNT1) ? cnt1_r :
                    (item_r == IT_CNT2) ? cnt2_r : serial_no;
  alcs_blk u_blk (
    .value(view_src),
    .blk(blk_r),
    .digits(blk_digits)
  );
  always_ff @(posedge mclk) begin
    if (reset) volt_sel_r <= 1'b0;
    else if (!fault) volt_sel_r <= 1'b0;
    else if (up_rise) volt_sel_r <= !volt_sel_r;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      disp_val <= 10'h000;
      disp_dp <= 4'h0;
      disp_blink <= 1'b0;
    end else begin
      disp_dp <= 4'h0;
      disp_blink <= 1'b0;
      case (state_r)
        ST_FAULT: disp_val <= volt_sel_r ? volt_us : volt_ua;
        ST_PIN: disp_val <= {6'h00, dig_r};
        ST_EDIT: disp_val <= edit_r;
        ST_VIEW: begin
          disp_val <= blk_digits;
          disp_dp <= 4'h1 << blk_r;
          disp_blink <= (blk_r == 2'h0);
        end
        default: disp_val <= 10'h000;
      endcase
    end
  end
  a_view_first: assert property (state_r == ST_IDLE && menu_short &&
    sel_item == IT_CNT1 && !err_act && !fault
    |=> ##1 disp_blink && disp_dp == 4'h1)
    else $error("counter view did not start at lowest block");

  // outputs, protection and IO-Link parameter port
  logic shutdown_r, ok_c;
  logic [15:0] rd_c;
  always_ff @(posedge mclk) begin
    if (reset) shutdown_r <= 1'b0;
    else if (temp_s) shutdown_r <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      vac_en <= 1'b0;
      parts_out <= 1'b0;
      pump_off <= 1'b0;
      err_code <= `ALCS_ERR_NONE;
      write_grant <= 1'b0;
    end else begin
      vac_en <= suc_s && !fault && !shutdown_r;
      parts_out <= parts_in;
      pump_off <= shutdown_r || temp_s;
      err_code <= err_c;
      write_grant <= grant_c;
    end
  end
  a_fault_vac: assert property (fault |=> !vac_en)
    else $error("vacuum on during supply fault");
  always_comb begin
    rd_c = 16'h0000;
    ok_c = 1'b1;
    case (iol_index)
      `ALCS_IDX_LOCK: rd_c = lock_r;
      `ALCS_IDX_TAG: rd_c = tag_r;
      `ALCS_IDX_PIN: begin rd_c = {6'h00, pin_r}; ok_c = !iol_wr || wr_rng; end
      `ALCS_IDX_CFG: begin rd_c = {6'h00, cfg_r}; ok_c = !iol_wr || wr_rng; end
      `ALCS_IDX_PROF: begin rd_c = {6'h00, prof_r}; ok_c = !iol_wr || wr_rng; end
      `ALCS_IDX_FRESET: rd_c = 16'h0000;
      `ALCS_IDX_ERR: begin rd_c = {8'h00, err_c}; ok_c = !iol_wr; end
      `ALCS_IDX_CNT1_LO: begin rd_c = cnt1_r[15:0]; ok_c = !iol_wr; end
      `ALCS_IDX_CNT1_HI: begin rd_c = cnt1_r[31:16]; ok_c = !iol_wr; end
      `ALCS_IDX_CNT2_LO: begin rd_c = cnt2_r[15:0]; ok_c = !iol_wr; end
      `ALCS_IDX_CNT2_HI: begin rd_c = cnt2_r[31:16]; ok_c = !iol_wr; end
      default: ok_c = 1'b0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      iol_ack <= 1'b0;
      iol_nak <= 1'b0;
      iol_rdata <= 16'h0000;
    end else begin
      iol_ack <= (iol_w_c || iol_r_c) && ok_c;
      iol_nak <= (iol_w_c || iol_r_c) && !ok_c;
      if (iol_r_c) iol_rdata <= ok_c ? rd_c : 16'h0000;
    end
  end
endmodule

// ### testbench/alcs_master.sv
// Purpose: IO-Link master model for the parameter port
// Assumes: answer comes one cycle after the request is taken
// Notes: released lines carry inverted values, not the old ones
`timescale 1ns/100ps
module alcs_master (
  input wire logic mclk,
  output logic iol_wr,
  output logic iol_rd,
  output logic [15:0] iol_index,
  output logic [15:0] iol_wdata,
  input wire logic [15:0] iol_rdata,
  input wire logic iol_ack,
  input wire logic iol_nak
);
  initial begin
    iol_wr = 1'h0;
    iol_rd = 1'h0;
    iol_index = 16'h0000;
    iol_wdata = 16'h0000;
  end
  // one strobe cycle, answer sampled at the following rising edge
  task automatic xfer(input logic w, input logic [15:0] idx, wd,
      output logic [15:0] rd, output logic [1:0] rsp);
    @(negedge mclk);
    iol_wr = w;
    iol_rd = ~w;
    iol_index = idx; // master alone sets or clears the lock
    iol_wdata = wd;
    @(negedge mclk);
    iol_wr = 1'h0;
    iol_rd = 1'h0;
    iol_index = ~idx;
    iol_wdata = ~wd;
    @(posedge mclk);
    rd = iol_rdata;
    rsp = {iol_nak, iol_ack};
    @(negedge mclk);
  endtask
endmodule

// ### testbench/tb_access_lock_counter_supervisor.sv
// Purpose: self-checking bench of the access lock supervisor
// Assumes: TICK_CYC of 4, so one second is 40 cycles
// Notes: inputs change on falling edges
`timescale 1ns/100ps
module tb_access_lock_counter_supervisor;
  import alcs_pkg::*;
  logic mclk, reset, suction_in, temp_over, parts_in, iol_mode;
  logic iol_wr, iol_rd, iol_ack, iol_nak, vac_en, parts_out;
  logic disp_blink, pump_off, write_grant;
  logic [2:0] keys;
  logic [3:0] sup, disp_dp;
  logic [15:0] iol_index, iol_wdata, iol_rdata, rd;
  logic [7:0] err_code, ext_err;
  logic [9:0] disp_val;
  logic [31:0] serial_no;
  logic [1:0] rsp;
  alcs_item_t sel_item;
  alcs_msg_t disp_msg;
  int checks = 0;
  int mismatches = 0;
  alcs_top #(.TICK_CYC(4)) i_dut (.mclk, .reset, .key_menu(keys[0]),
    .key_up(keys[1]), .key_down(keys[2]), .suction_in,
    .sup_ua_low(sup[0]), .sup_ua_high(sup[1]), .sup_us_low(sup[2]),
    .sup_us_high(sup[3]), .temp_over, .parts_in, .ext_err,
    .volt_ua(10'h0F0), .volt_us(10'h0F1), .serial_no, .sel_item,
    .iol_mode, .iol_wr, .iol_rd, .iol_index, .iol_wdata, .iol_rdata,
    .iol_ack, .iol_nak, .disp_val, .disp_dp, .disp_blink, .disp_msg,
    .err_code, .vac_en, .parts_out, .pump_off, .write_grant);
  alcs_master i_master (.mclk, .iol_wr, .iol_rd, .iol_index, .iol_wdata,
    .iol_rdata, .iol_ack, .iol_nak);
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic io(input logic w, input logic [15:0] i, d,
      input logic [1:0] r);
    i_master.xfer(w, i, d, rd, rsp);
    chk(rsp, r);
  endtask
  task automatic press(input int k, input int n);
    cyc(1);
    repeat (n) begin
      keys[k] = 1'h1;
      cyc(8);
      keys[k] = 1'h0;
      cyc(8);
    end
  endtask
  task automatic t_reset;
    cyc(3);
    chk(write_grant, 1'h1);
    io(1'h0, 16'h0040, 16'h0000, 2'h1);
    chk(rd, 16'h0000);
  endtask
  task automatic t_count;
    logic [15:0] c0;
    repeat (3) begin
      cyc(6);
      suction_in = 1'h1;
      cyc(6);
      suction_in = 1'h0;
    end
    cyc(6);
    io(1'h0, 16'h0043, 16'h0000, 2'h1);
    chk(rd, 16'h0003);
    io(1'h1, 16'h0043, 16'h0000, 2'h2);
    io(1'h0, 16'h0045, 16'h0000, 2'h1);
    c0 = rd;
    cyc(37);
    io(1'h0, 16'h0045, 16'h0000, 2'h1);
    chk(rd - c0, 16'h0001);
  endtask
  task automatic t_fres;
    io(1'h1, 16'h0047, 16'h1234, 2'h1);
    io(1'h1, 16'h0040, 16'h0007, 2'h1);
    cyc(2);
    chk(write_grant, 1'h0);
    io(1'h1, 16'h0048, 16'h0055, 2'h1);
    io(1'h1, 16'h0041, 16'h0001, 2'h1);
    cyc(2);
    chk(write_grant, 1'h1);
    io(1'h0, 16'h0048, 16'h0000, 2'h1);
    chk(rd, 16'h0000);
    io(1'h0, 16'h0047, 16'h0000, 2'h1);
    chk(rd, 16'h1234);
    io(1'h0, 16'h0043, 16'h0000, 2'h1);
    chk(rd, 16'h0003);
  endtask
  task automatic t_lock;
    io(1'h1, 16'h000C, 16'h0004, 2'h1);
    cyc(2);
    chk(write_grant, 1'h0);
    iol_mode = 1'h0;
    press(0, 1);
    chk(disp_msg, MSG_LOCKED);
    chk(write_grant, 1'h0);
    iol_mode = 1'h1;
    io(1'h0, 16'h000C, 16'h0000, 2'h1);
    chk(rd, 16'h0004);
    io(1'h1, 16'h000C, 16'h0000, 2'h1);
    cyc(2);
    chk(write_grant, 1'h1);
    press(0, 1);
    press(1, 3);
    chk(disp_val, 10'h003);
    keys[1] = 1'h1;
    cyc(200);
    keys[1] = 1'h0;
    chk(disp_val > 10'h004, 1'h1);
    press(0, 1);
    io(1'h0, 16'h0048, 16'h0000, 2'h1);
    chk(rd, 16'h0000);
  endtask
  task automatic t_pin;
    int n;
    io(1'h1, 16'h0040, 16'h03E8, 2'h2);
    io(1'h1, 16'h0040, 16'h0005, 2'h1);
    cyc(2);
    chk(write_grant, 1'h0);
    press(0, 4);
    chk(disp_msg, MSG_PIN_BAD);
    chk(write_grant, 1'h0);
    press(0, 3);
    press(1, 5);
    press(0, 1);
    chk(disp_msg, MSG_PIN_OK);
    cyc(2250);
    chk(write_grant, 1'h1);
    n = 200;
    while (write_grant !== 1'h0 && n > 0) begin
      cyc(1);
      n--;
    end
    if (n == 0) begin
      mismatches++;
      wrap_up();
    end
    chk(write_grant, 1'h0);
  endtask
  task automatic t_view;
    serial_no = 32'h02E5DC61;
    sel_item = IT_SERIAL;
    press(0, 1);
    chk({disp_blink, disp_dp, disp_val}, {1'h1, 4'h1, 10'h251});
    press(1, 1);
    chk({disp_blink, disp_dp, disp_val}, {1'h0, 4'h2, 10'h26A});
    press(1, 1);
    chk({disp_dp, disp_val}, {4'h4, 10'h030});
    press(0, 1);
    sel_item = IT_CNT1;
    press(0, 1);
    chk({disp_blink, disp_dp, disp_val}, {1'h1, 4'h1, 10'h003});
    press(1, 1);
    chk({disp_dp, disp_val}, {4'h2, 10'h000});
    press(2, 1);
    chk(disp_dp, 4'h1);
    press(0, 1);
  endtask
  task automatic t_fault;
    logic [7:0] code [4] = '{8'h05, 8'h15, 8'h07, 8'h17};
    sel_item = IT_CFG;
    press(0, 1);
    press(1, 2);
    chk(disp_val, 10'h002);
    ext_err = 8'h21;
    cyc(2);
    chk(err_code, 8'h21);
    chk(disp_val, 10'h000);
    chk(disp_msg, MSG_ERR);
    io(1'h0, 16'h0042, 16'h0000, 2'h1);
    chk(rd, 16'h0021);
    ext_err = 8'h00;
    suction_in = 1'h1;
    cyc(6);
    chk(vac_en, 1'h1);
    for (int i = 0; i < 4; i++) begin
      sup = 4'h1 << i;
      parts_in = i[0];
      cyc(6);
      chk(err_code, code[i]);
      chk(vac_en, 1'h0);
      chk(parts_out, i[0]);
      chk(disp_msg, MSG_ERR);
      io(1'h0, 16'h0042, 16'h0000, 2'h1);
      chk(rd, code[i]);
    end
    press(0, 1);
    chk(disp_blink, 1'h0);
    chk(disp_val, 10'h0F0);
    press(1, 1);
    chk(disp_val, 10'h0F1);
    sup = 4'h0;
    cyc(6);
    chk(vac_en, 1'h1);
    temp_over = 1'h1;
    cyc(6);
    chk(pump_off, 1'h1);
    chk(vac_en, 1'h0);
    chk(err_code, 8'h0C);
  endtask
  initial begin
    reset = 1'h1;
    keys = 3'h0;
    sup = 4'h0;
    suction_in = 1'h0;
    temp_over = 1'h0;
    parts_in = 1'h0;
    ext_err = 8'h00;
    iol_mode = 1'h1;
    serial_no = 32'h00000000;
    sel_item = IT_CFG;
    cyc(6);
    reset = 1'h0;
    t_reset();
    t_count();
    t_fres();
    t_lock();
    t_pin();
    t_view();
    t_fault();
    wrap_up();
  end
endmodule
